// ==== acl_map.svh ====
// Register offsets, field positions, reset values and timing counts of the ACL evaluator.
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH
`define RULE_BASE     12'h000
`define ACT_BASE      12'h100
`define ENT_BASE      12'h140
`define STAT_ADDR     12'h180
`define FLAG_ADDR     12'h184
`define RESET_WORD    32'h0000_0000
`define CTRL_MODE     1:0
`define CTRL_OPT      3:2
`define CTRL_DIR      4
`define CTRL_POL      5
`define ACT_COUNT     10:0
`define ACT_TU        11
`define ACT_CA        12
`define ENT_MASK      15:0
`define ENT_PTR       19:16
`define RESP_OKAY     2'b00
`define RESP_DECERR   2'b11
`define CLK_PERIOD_NS 4
`define US_NS         1000
`define MS_NS         1000000
`define US_CYCLES     ((`US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_CYCLES_DEF ((`MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== acl_pkg.sv ====
// Types shared by the ACL evaluator and its bench.
package acl_pkg;
    typedef enum logic [1:0] {MODE_OFF, MODE_L2, MODE_L3, MODE_L4} layer_mode_t;
    typedef enum logic [2:0] {REG_RULE, REG_ACT, REG_ENT, REG_STAT, REG_FLAG, REG_NONE} region_t;
    typedef struct packed {
        logic        match_polarity;
        logic        addr_dir;
        logic [1:0]  match_option_select;
        layer_mode_t match_layer_mode;
        logic [31:0] d0;
        logic [31:0] d1;
        logic [15:0] d2;
    } rule_t;
    typedef struct packed {
        logic [3:0]  action_pointer;
        logic [15:0] selected_match_mask;
    } entry_t;
    typedef struct packed {
        logic [47:0] dst_mac;
        logic [47:0] src_mac;
        logic [15:0] ethertype;
        logic [31:0] src_ip;
        logic [31:0] dst_ip;
        logic [7:0]  protocol;
        logic        is_tcp;
        logic        is_udp;
        logic [15:0] src_port;
        logic [15:0] dst_port;
        logic [31:0] tcp_seq;
    } pkt_t;
    typedef struct packed {
        logic        hit;
        logic [3:0]  action;
        logic [12:0] action_word;
    } result_t;
    typedef struct packed {
        rule_t [15:0]       rule;
        logic [15:0][12:0]  act;
        entry_t [15:0]      ent;
        logic [15:0][10:0]  cnt;
        logic [15:0]        armed;
        logic [15:0]        flags;
        logic               aw_held;
        logic               w_held;
        logic [11:0]        awaddr;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic [7:0]         us_cnt;
        logic [17:0]        ms_cnt;
        logic               us_tick;
        logic               ms_tick;
        logic               s1_valid;
        logic [15:0]        s1_match;
        logic [15:0]        hits;
        logic               res_valid;
        result_t            res;
        logic               alarm;
    } state_t;
endpackage

// ==== acl_rule_evaluator.sv ====
// Ingress ACL evaluator: matching rules, processing entries, counters and AXI4-Lite registers.
// What this block does
// R1: At most one action per packet; lowest action pointer among true entries wins.
// R2: An entry is true only when all rules in its selected match mask are true.
// R3: Entries sharing one action pointer are ORed together.
// R4: Layer mode 00 disables the rule; it never yields true.
// R5: Layer mode picks layer 2, layer 3 or layer 4 comparison.
// R6: Layer 2 option: 00 counter, 01 MAC, 10 EtherType, 11 both.
// R7: Address direction bit: 0 destination, 1 source.
// R8: Polarity 1 makes equal true; polarity 0 makes unequal true.
// R9: Counter mode takes its 11-bit count value from the action entry fields.
// R10: Count time unit bit: 0 microseconds, 1 milliseconds.
// R11: Count algorithm 0: watchdog down-counter reloads per packet, alarms on expiry.
// R12: Count algorithm 1: count matching packets, alarm at terminal count, restart.
// R13: Counter rule owns same-index action entry, which never forwards.
// R14: Layer 3 option 01 masked single address, 10 both exact, others reserved.
// R15: Layer 3 mask bit 0 compares the address bit, 1 ignores it.
// R16: Layer 3 option 10: address field is source, mask field is destination.
// R17: Layer 4 option: 00 protocol, 01 TCP port, 10 UDP port, 11 sequence.
// R18: Each entry has a 16-bit mask, one bit per matching rule.
// R19: Each entry has a 4-bit action pointer to action entries 0 to 15.
// R20: The result is issued only after every rule and entry is evaluated.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`include "acl_map.svh"

module acl_rule_evaluator
    import acl_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES_DEF
) (
    // Clock, reset and freeze.
    input  wire logic    clk,
    input  wire logic    rst_n,
    input  wire logic    ce,
    // AXI4-Lite register port.
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Parsed frame from the ingress parser.
    input  wire logic    pkt_valid,
    input  wire pkt_t    pkt,
    // Decision and counter alarm.
    output logic         result_valid,
    output result_t      result,
    output logic         count_alarm
);
    state_t      s;
    state_t      n;
    logic [15:0] fire;
    logic [15:0] tick;
    logic [15:0] evt;
    logic [15:0] clr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic region_t region(input logic [11:0] a);
        if (a < `ACT_BASE) return REG_RULE;
        if (a < `ENT_BASE) return REG_ACT;
        if (a < `STAT_ADDR) return REG_ENT;
        if (a[11:2] == `STAT_ADDR >> 2) return REG_STAT;
        if (a[11:2] == `FLAG_ADDR >> 2) return REG_FLAG;
        return REG_NONE;
    endfunction

    function automatic logic [31:0] rule_word(input rule_t r, input logic [1:0] sel);
        logic [31:0] w;
        w = `RESET_WORD;
        unique case (sel)
            2'd0: begin
                w[`CTRL_MODE] = r.match_layer_mode;
                w[`CTRL_OPT] = r.match_option_select;
                w[`CTRL_DIR] = r.addr_dir;
                w[`CTRL_POL] = r.match_polarity;
            end
            2'd1: w = r.d0;
            2'd2: w = r.d1;
            2'd3: w[15:0] = r.d2;
        endcase
        return w;
    endfunction

    function automatic logic is_count(input rule_t r);
        return r.match_layer_mode == MODE_L2 && r.match_option_select == 2'b00; // see R6
    endfunction

    function automatic logic sense(input logic pol, input logic eq);
        return pol ? eq : !eq; // see R8
    endfunction

    function automatic logic match_rule(input rule_t r, input pkt_t p);
        logic [47:0] mac;
        logic [31:0] ip;
        logic [15:0] port;
        logic        mac_eq;
        logic        type_eq;
        logic        res;
        mac = r.addr_dir ? p.src_mac : p.dst_mac; // see R7
        ip = r.addr_dir ? p.src_ip : p.dst_ip;
        port = r.addr_dir ? p.src_port : p.dst_port;
        mac_eq = mac == {r.d1[15:0], r.d0};
        type_eq = p.ethertype == r.d2;
        res = 1'b0;
        unique case (r.match_layer_mode) // see R5
            MODE_OFF: res = 1'b0; // see R4
            MODE_L2: begin
                unique case (r.match_option_select) // see R6
                    2'b01: res = sense(r.match_polarity, mac_eq);
                    2'b10: res = sense(r.match_polarity, type_eq);
                    default: res = sense(r.match_polarity, mac_eq && type_eq);
                endcase
            end
            MODE_L3: begin
                unique case (r.match_option_select) // see R14
                    2'b01: res = sense(r.match_polarity, ((ip ^ r.d0) & ~r.d1) == 32'h0); // see R15
                    2'b10: res = sense(r.match_polarity, p.src_ip == r.d0 && p.dst_ip == r.d1); // see R16
                    default: res = 1'b0;
                endcase
            end
            MODE_L4: begin
                unique case (r.match_option_select) // see R17
                    2'b00: res = sense(r.match_polarity, p.protocol == r.d2[7:0]);
                    2'b01: res = p.is_tcp && sense(r.match_polarity, port == r.d0[15:0]);
                    2'b10: res = p.is_udp && sense(r.match_polarity, port == r.d0[15:0]);
                    2'b11: res = p.is_tcp && sense(r.match_polarity, p.tcp_seq == r.d0);
                endcase
            end
        endcase
        return res;
    endfunction

    always_comb begin
        logic [31:0] w;
        logic [3:0]  idx;
        n = s;
        w = `RESET_WORD;
        idx = 4'h0;
        evt = 16'h0;
        clr = 16'h0;
        // Time base shared by all counter rules.
        n.us_tick = s.us_cnt == 8'(`US_CYCLES - 1);
        n.us_cnt = n.us_tick ? 8'h00 : s.us_cnt + 8'h01;
        n.ms_tick = s.ms_cnt == 18'(MS_CYCLES - 1);
        n.ms_cnt = n.ms_tick ? 18'h0 : s.ms_cnt + 18'h1;
        // Stage one: every matching rule against the frame.
        n.s1_valid = pkt_valid;
        for (int i = 0; i < 16; i++) begin
            if (pkt_valid) begin
                n.s1_match[i] = match_rule(s.rule[i], pkt);
            end
        end
        // Stage two: processing entries and priority pick.
        n.res_valid = s.s1_valid; // see R20
        n.hits = 16'h0;
        for (int e = 0; e < 16; e++) begin
            if (s.s1_valid && s.ent[e].selected_match_mask != 16'h0
                && (s.s1_match & s.ent[e].selected_match_mask) == s.ent[e].selected_match_mask // see R2 R18
                && !is_count(s.rule[s.ent[e].action_pointer])) begin // see R13
                n.hits[s.ent[e].action_pointer] = 1'b1; // see R3 R19
            end
        end
        if (s.s1_valid) begin
            n.res.hit = |n.hits;
            n.res.action = 4'h0;
            for (int a = 15; a >= 0; a--) begin
                if (n.hits[a]) begin
                    n.res.action = 4'(a); // see R1
                end
            end
            n.res.action_word = s.act[n.res.action];
        end
        // Counter rules, using the action entry at the same index.
        for (int i = 0; i < 16; i++) begin
            fire[i] = s.s1_valid && s.s1_match[i] && is_count(s.rule[i]);
            tick[i] = s.act[i][`ACT_TU] ? s.ms_tick : s.us_tick; // see R10
            if (!s.act[i][`ACT_CA]) begin
                if (fire[i]) begin
                    n.cnt[i] = s.act[i][`ACT_COUNT]; // see R9 R11
                    n.armed[i] = 1'b1;
                end else if (s.armed[i] && tick[i]) begin
                    if (s.cnt[i] <= 11'h001) begin
                        evt[i] = 1'b1;
                        n.armed[i] = 1'b0;
                        n.cnt[i] = 11'h000;
                    end else begin
                        n.cnt[i] = s.cnt[i] - 11'h001; // see R11
                    end
                end
            end else begin
                n.armed[i] = 1'b0;
                if (fire[i]) begin
                    if ({1'b0, s.cnt[i]} + 12'h001 >= {1'b0, s.act[i][`ACT_COUNT]}) begin
                        evt[i] = 1'b1; // see R12
                        n.cnt[i] = 11'h000;
                    end else begin
                        n.cnt[i] = s.cnt[i] + 11'h001;
                    end
                end
            end
        end
        // AXI4-Lite write channel.
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (awvalid && s.awready) begin
            n.aw_held = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && s.wready) begin
            n.w_held = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (s.aw_held && s.w_held && !s.bvalid) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OKAY;
            unique case (region(s.awaddr))
                REG_RULE: begin
                    idx = s.awaddr[7:4];
                    w = merge(rule_word(s.rule[idx], s.awaddr[3:2]), s.wdata, s.wstrb);
                    unique case (s.awaddr[3:2])
                        2'd0: begin
                            n.rule[idx].match_layer_mode = layer_mode_t'(w[`CTRL_MODE]);
                            n.rule[idx].match_option_select = w[`CTRL_OPT];
                            n.rule[idx].addr_dir = w[`CTRL_DIR];
                            n.rule[idx].match_polarity = w[`CTRL_POL];
                        end
                        2'd1: n.rule[idx].d0 = w;
                        2'd2: n.rule[idx].d1 = w;
                        2'd3: n.rule[idx].d2 = w[15:0];
                    endcase
                end
                REG_ACT: begin
                    idx = s.awaddr[5:2];
                    w = merge({19'h0, s.act[idx]}, s.wdata, s.wstrb);
                    n.act[idx] = w[12:0];
                end
                REG_ENT: begin
                    idx = s.awaddr[5:2];
                    w = merge({12'h0, s.ent[idx]}, s.wdata, s.wstrb);
                    n.ent[idx].selected_match_mask = w[`ENT_MASK];
                    n.ent[idx].action_pointer = w[`ENT_PTR];
                end
                REG_FLAG: begin
                    w = merge(`RESET_WORD, s.wdata, s.wstrb);
                    clr = w[15:0];
                end
                REG_STAT: n.bresp = `RESP_OKAY;
                REG_NONE: n.bresp = `RESP_DECERR;
            endcase
        end
        // Set wins over a clear in the same cycle.
        n.flags = (s.flags & ~clr) | evt;
        // AXI4-Lite read channel.
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = `RESP_OKAY;
            n.rdata = `RESET_WORD;
            unique case (region(araddr))
                REG_RULE: n.rdata = rule_word(s.rule[araddr[7:4]], araddr[3:2]);
                REG_ACT: n.rdata = {19'h0, s.act[araddr[5:2]]};
                REG_ENT: n.rdata = {12'h0, s.ent[araddr[5:2]]};
                REG_STAT: n.rdata = {27'h0, s.res.hit, s.res.action};
                REG_FLAG: n.rdata = {16'h0, s.flags};
                REG_NONE: n.rresp = `RESP_DECERR;
            endcase
        end
        n.awready = !n.aw_held;
        n.wready = !n.w_held;
        n.arready = !n.rvalid;
        n.alarm = |n.flags;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign result_valid = s.res_valid;
    assign result = s.res;
    assign count_alarm = s.alarm;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence pkt_in;
        pkt_valid ##1 ce;
    endsequence
    sequence result_out;
        ce ##0 result_valid;
    endsequence

    AST_LATENCY: assert property (pkt_in |=> result_out) // see R20
        else $error("result not issued two cycles after frame");
    AST_LOWEST: assert property (result_valid && result.hit
        |-> s.hits[result.action] && (s.hits & ((16'h1 << result.action) - 16'h1)) == 16'h0) // see R1
        else $error("winning action is not the lowest true one");
    AST_OR: assert property (result_valid |-> result.hit == (s.hits != 16'h0)) // see R3
        else $error("hit flag disagrees with entry results");
    AST_AND: assert property (s.s1_valid && s.ent[0].selected_match_mask != 16'h0
        && (s.s1_match & s.ent[0].selected_match_mask) == s.ent[0].selected_match_mask
        && !is_count(s.rule[s.ent[0].action_pointer]) |=> s.hits[$past(s.ent[0].action_pointer)]) // see R2
        else $error("entry with all rules true gave no hit");
    AST_OFF: assert property (pkt_valid && s.rule[0].match_layer_mode == MODE_OFF |=> !s.s1_match[0]) // see R4
        else $error("disabled rule reported a match");
    AST_MASK: assert property (pkt_valid && s.rule[0].match_layer_mode == MODE_L3
        && s.rule[0].match_option_select == 2'b01 && s.rule[0].match_polarity
        && ((pkt.dst_ip ^ s.rule[0].d0) & ~s.rule[0].d1) == 32'h0 && !s.rule[0].addr_dir
        |=> s.s1_match[0]) // see R15
        else $error("masked address match missed");
    AST_WDOG: assert property (!s.act[0][`ACT_CA] && s.armed[0] && s.cnt[0] == 11'h001
        && tick[0] && !fire[0] |=> s.flags[0] && count_alarm) // see R11
        else $error("watchdog expiry did not raise the alarm");
    AST_EVENT: assert property (s.act[0][`ACT_CA] && fire[0]
        && {1'b0, s.cnt[0]} + 12'h001 >= {1'b0, s.act[0][`ACT_COUNT]} |=> s.flags[0] && s.cnt[0] == 11'h000) // see R12
        else $error("event counter did not fire and restart");
endmodule // acl_rule_evaluator

// ==== acl_far_side.sv ====
// Far-side model: frame source and result sink.
module acl_far_side
    import acl_pkg::*;
(
    // Clock.
    input  wire logic    clk,
    // Frame to the evaluator.
    output logic         pkt_valid,
    output pkt_t         pkt,
    // Decision from the evaluator.
    input  wire logic    result_valid,
    input  wire result_t result
);
    timeunit 1ns;
    timeprecision 1ps;
    pkt_t    tx[$];
    result_t got[$];
    initial begin
        pkt_valid = 1'b0;
        pkt = '0;
    end
    // Between frames the bus toggles so stale fields never match.
    always @(posedge clk) begin
        if (tx.size() > 0) begin
            pkt_valid <= 1'b1;
            pkt <= tx.pop_front();
        end else begin
            pkt_valid <= 1'b0;
            pkt <= ~pkt;
        end
        if (result_valid === 1'b1) begin
            got.push_back(result);
        end
    end
endmodule // acl_far_side

// ==== tb_acl_rule_evaluator.sv ====
// Self-checking bench of the ACL evaluator.
`include "acl_map.svh"
module tb_acl_rule_evaluator
    import acl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 20;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, pkt_valid, result_valid, count_alarm;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    pkt_t        pkt;
    result_t     result;
    rule_t       rules[16];
    logic [12:0] acts[16];
    entry_t      ents[16];
    int          err_total = 0, compares = 0;

    always #2 clk = ~clk;

    acl_rule_evaluator #(.MS_CYCLES(MS)) dut (.clk, .rst_n, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .pkt_valid, .pkt, .result_valid, .result, .count_alarm);
    acl_far_side far (.clk, .pkt_valid, .pkt, .result_valid, .result);

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp = `RESP_OKAY);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check_word("bresp", 32'(exp), 32'(bresp));
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] exp = `RESP_OKAY);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        check_word("rresp", 32'(exp), 32'(rresp));
        rready <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [3:0] nib();
        return ($urandom % 2) ? 4'ha : 4'h5;
    endfunction

    function automatic pkt_t rand_pkt();
        pkt_t p;
        p.dst_mac = {nib(), nib(), nib(), nib(), {8{nib()}}};
        p.src_mac = {nib(), nib(), nib(), nib(), {8{nib()}}};
        p.ethertype = {4{nib()}};
        p.src_ip = {8{nib()}};
        p.dst_ip = {8{nib()}};
        p.protocol = {2{nib()}};
        p.is_tcp = 1'($urandom);
        p.is_udp = 1'($urandom);
        p.src_port = {4{nib()}};
        p.dst_port = {4{nib()}};
        p.tcp_seq = {8{nib()}};
        return p;
    endfunction

    function automatic logic rmatch(rule_t r, pkt_t p);
        logic [47:0] mac;
        logic [31:0] ip;
        logic [15:0] port;
        logic        eq;
        mac = r.addr_dir ? p.src_mac : p.dst_mac;
        ip = r.addr_dir ? p.src_ip : p.dst_ip;
        port = r.addr_dir ? p.src_port : p.dst_port;
        case ({r.match_layer_mode, r.match_option_select})
            4'h5: eq = (mac == {r.d1[15:0], r.d0});
            4'h6: eq = (p.ethertype == r.d2);
            4'h7: eq = (mac == {r.d1[15:0], r.d0}) && (p.ethertype == r.d2);
            4'h9: eq = ((ip ^ r.d0) & ~r.d1) == 32'h0;
            4'ha: eq = (p.src_ip == r.d0) && (p.dst_ip == r.d1);
            4'hc: eq = (p.protocol == r.d2[7:0]);
            4'hd: return p.is_tcp && ((port == r.d0[15:0]) == r.match_polarity);
            4'he: return p.is_udp && ((port == r.d0[15:0]) == r.match_polarity);
            4'hf: return p.is_tcp && ((p.tcp_seq == r.d0) == r.match_polarity);
            default: return 1'b0;
        endcase
        return eq == r.match_polarity;
    endfunction

    function automatic result_t expect_dec(pkt_t p);
        logic [15:0] h;
        result_t     x;
        x = '0;
        for (int i = 0; i < 16; i++) h[i] = rmatch(rules[i], p);
        for (int e = 0; e < 16; e++) begin
            if (ents[e].selected_match_mask != 16'h0 && (ents[e].selected_match_mask & ~h) == 16'h0
                && (!x.hit || ents[e].action_pointer < x.action)) begin
                x.hit = 1'b1;
                x.action = ents[e].action_pointer;
            end
        end
        x.action_word = acts[x.action];
        return x;
    endfunction

    task automatic config_random();
        for (int i = 0; i < 16; i++) begin
            rules[i].match_layer_mode = layer_mode_t'($urandom % 4);
            rules[i].match_option_select = 2'($urandom);
            if (rules[i].match_layer_mode == MODE_L2 && rules[i].match_option_select == 2'b00) begin
                rules[i].match_option_select = 2'b01;
            end
            rules[i].addr_dir = 1'($urandom);
            rules[i].match_polarity = 1'($urandom);
            rules[i].d0 = {8{nib()}};
            rules[i].d1 = {8{nib()}};
            rules[i].d2 = {4{nib()}};
            acts[i] = 13'($urandom);
            ents[i].selected_match_mask = 16'(1 << ($urandom % 16)) | 16'(($urandom % 2) << ($urandom % 16));
            if ($urandom % 5 == 0) ents[i].selected_match_mask = 16'h0;
            ents[i].action_pointer = 4'($urandom);
            axi_wr(`RULE_BASE + 12'(16 * i), {26'h0, rules[i][85:80]});
            axi_wr(`RULE_BASE + 12'(16 * i + 4), rules[i].d0);
            axi_wr(`RULE_BASE + 12'(16 * i + 8), rules[i].d1);
            axi_wr(`RULE_BASE + 12'(16 * i + 12), {16'h0, rules[i].d2});
            axi_wr(`ACT_BASE + 12'(4 * i), {19'h0, acts[i]});
            axi_wr(`ENT_BASE + 12'(4 * i), {12'h0, ents[i]});
        end
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED run expected done seen timeout");
        print_verdict();
    end

    initial begin
        pkt_t        ps[2];
        result_t     g, x;
        logic [31:0] d;
        int          unit, lo, hi;
        void'($urandom(84095));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        axi_rd(`ENT_BASE, d);
        check_word("entry reset", `RESET_WORD, d);
        axi_rd(12'h200, d, `RESP_DECERR);
        check_word("unmapped rdata", 32'h0, d);
        axi_wr(12'h200, 32'h1, `RESP_DECERR);
        for (int k = 0; k < 4; k++) begin
            config_random();
            axi_rd(`ENT_BASE + 12'h3c, d);
            check_word("entry readback", {12'h0, ents[15]}, d);
            for (int n = 0; n < 10; n++) begin
                // Back-to-back frames test the pipeline.
                foreach (ps[j]) begin
                    ps[j] = rand_pkt();
                    far.tx.push_back(ps[j]);
                end
                while (far.got.size() < 2) @(posedge clk);
                foreach (ps[j]) begin
                    g = far.got.pop_front();
                    x = expect_dec(ps[j]);
                    check_word("hit", 32'(x.hit), 32'(g.hit));
                    if (x.hit) begin
                        check_word("action", 32'(x.action), 32'(g.action));
                        check_word("action word", 32'(x.action_word), 32'(g.action_word));
                    end
                end
            end
            axi_rd(`STAT_ADDR, d);
            check_word("status hit", 32'(x.hit), 32'(d[4]));
            if (x.hit) check_word("status action", 32'(x.action), 32'(d[3:0]));
        end
        for (int i = 0; i < 16; i++) begin
            axi_wr(`RULE_BASE + 12'(16 * i), 32'h0);
            axi_wr(`ENT_BASE + 12'(4 * i), 32'h0);
        end
        // Rule 0 is an event counter.
        axi_wr(`RULE_BASE, 32'h21);
        axi_wr(`RULE_BASE + 12'h4, 32'h5555_5555);
        axi_wr(`RULE_BASE + 12'h8, 32'h0000_5555);
        axi_wr(`RULE_BASE + 12'hc, 32'h0000_5555);
        axi_wr(`ENT_BASE, 32'h0000_0001);
        axi_wr(`ACT_BASE, 32'h0000_1003);
        ps[0] = rand_pkt();
        ps[0].dst_mac = 48'h5555_5555_5555;
        ps[0].ethertype = 16'h5555;
        for (int n = 1; n <= 3; n++) begin
            far.tx.push_back(ps[0]);
            while (far.got.size() < 1) @(posedge clk);
            g = far.got.pop_front();
            check_word("count hit", 32'h0, 32'(g.hit));
            repeat (3) @(posedge clk);
            check_word("event alarm", 32'(n == 3), 32'(count_alarm));
        end
        axi_rd(`FLAG_ADDR, d);
        check_word("flags", 32'h1, d);
        axi_wr(`FLAG_ADDR, 32'h1);
        check_word("alarm cleared", 32'h0, 32'(count_alarm));
        for (int u = 0; u < 2; u++) begin
            unit = u ? MS : `US_CYCLES;
            lo = unit * (1 + u) - 10;
            hi = unit * (2 + u) + 20;
            axi_wr(`ACT_BASE, {20'h0, 1'(u), 11'(2 + u)});
            axi_wr(`FLAG_ADDR, 32'h1);
            far.tx.push_back(ps[0]);
            while (far.got.size() < 1) @(posedge clk);
            g = far.got.pop_front();
            repeat (lo) @(posedge clk);
            check_word("watchdog early", 32'h0, 32'(count_alarm));
            repeat (hi - lo) @(posedge clk);
            check_word("watchdog expiry", 32'h1, 32'(count_alarm));
            axi_wr(`FLAG_ADDR, 32'h1);
        end
        print_verdict();
    end
endmodule // tb_acl_rule_evaluator
